// >>> src/opfs_map.vh
// Purpose: register map and field layout of the output pin function select block
// Assumes: 32-bit APB, one aligned word per register
// Notes: offsets are byte addresses
`ifndef OPFS_MAP_VH
`define OPFS_MAP_VH

`define OPFS_OFS_PINS_12_13 12'h000
`define OPFS_OFS_PINS_14_15 12'h004
`define OPFS_OFS_PINS_16_17 12'h008
`define OPFS_OFS_PINS_18_19 12'h00c
`define OPFS_OFS_PINS_20_21 12'h010
`define OPFS_OFS_PINS_22_23 12'h014
`define OPFS_OFS_PINS_24_25 12'h018
`define OPFS_OFS_SHIFT 2
`define OPFS_PAIR_CNT 7
`define OPFS_BIG_PAIR_FIRST 2

`define OPFS_SEL_W 5
`define OPFS_EVEN_LSB 0
`define OPFS_ODD_LSB 8
`define OPFS_SEL_RESET 5'h00
`define OPFS_SEL_NONE 5'h00

`define OPFS_FIRST_PIN 12
`define OPFS_PIN_CNT 14

`endif

// >>> src/opfs_pin_route.v
// Purpose: routes one peripheral output onto one remappable pin
// Assumes: function code n selects peripheral output n-1 of the function bus
// Notes: code zero or an unassigned code leaves the pin to port logic
`timescale 1ns/100ps
`default_nettype none
`include "opfs_map.vh"

module opfs_pin_route #(
	parameter FUNC_CNT = 31
) (
	input wire [`OPFS_SEL_W-1:0] func_sel_i,
	input wire [FUNC_CNT-1:0] func_out_i,
	input wire [FUNC_CNT-1:0] func_oe_i,
	input wire port_out_i,
	input wire port_oe_i,
	output wire pin_out_o,
	output wire pin_oe_o,
	output wire pin_periph_o
);

	wire [`OPFS_SEL_W-1:0] func_idx;
	wire func_valid;

	assign func_idx = func_sel_i - 5'h01;

	// zero or unassigned codes fall back to port
	assign func_valid = (func_sel_i != `OPFS_SEL_NONE) && (func_sel_i <= FUNC_CNT);

	assign pin_out_o = func_valid ? func_out_i[func_idx] : port_out_i;
	assign pin_oe_o = func_valid ? func_oe_i[func_idx] : port_oe_i;
	assign pin_periph_o = func_valid;

endmodule // opfs_pin_route
`default_nettype wire

// >>> src/opfs_top.v
// Purpose: output function select for remappable pins 12 to 25, APB slave
// Assumes: one clock, peripheral and port signals on that clock
// Notes: pair registers 16..25 exist only when LARGE_PKG is set
//
// Functional notes
// - each pin 12..25 has 5-bit selector
// - even pin bits 4:0, odd 12:8
// - bits 15:13 and 7:5 read zero
// - selectors read/write, cleared at reset
// - pins 16..25 registers only on large package
// - pin 15 upper, pin 14 lower, independent
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "opfs_map.vh"

module opfs_top #(
	parameter FUNC_CNT = 31,
	parameter LARGE_PKG = 1
) (
	input wire core_clk_i,
	input wire reset_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire [3:0] pstrb_i,
	output reg [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	input wire [FUNC_CNT-1:0] func_out_i,
	input wire [FUNC_CNT-1:0] func_oe_i,
	input wire [`OPFS_PIN_CNT-1:0] port_out_i,
	input wire [`OPFS_PIN_CNT-1:0] port_oe_i,
	output wire [`OPFS_PIN_CNT-1:0] pin_out_o,
	output wire [`OPFS_PIN_CNT-1:0] pin_oe_o,
	output wire [`OPFS_PIN_CNT-1:0] pin_periph_o
);

	// ==========================================
	// address decode
	// ==========================================
	wire [9:0] word_idx;
	wire aligned;
	wire in_range;
	wire present;
	wire hit;
	wire access;
	wire [2:0] pair_sel;

	assign word_idx = paddr_i[11:`OPFS_OFS_SHIFT];
	assign aligned = (paddr_i[1:0] == 2'h0);
	assign in_range = (word_idx < `OPFS_PAIR_CNT);
	assign pair_sel = word_idx[2:0];
	// upper pairs absent on small package
	assign present = in_range && ((LARGE_PKG != 0) || (pair_sel < `OPFS_BIG_PAIR_FIRST));
	assign hit = aligned && present;
	assign access = psel_i && penable_i;
	assign pready_o = 1'b1;
	assign pslverr_o = access && !hit;

	// ==========================================
	// selector registers
	// ==========================================
	reg [`OPFS_SEL_W-1:0] even_sel_q [0:`OPFS_PAIR_CNT-1];
	reg [`OPFS_SEL_W-1:0] odd_sel_q [0:`OPFS_PAIR_CNT-1];
	wire [`OPFS_PIN_CNT*`OPFS_SEL_W-1:0] sel_flat;

	genvar g;
	generate
		for (g = 0; g < `OPFS_PAIR_CNT; g = g + 1) begin : g_pair
			wire wr_this;
			wire keep;
			assign keep = (LARGE_PKG != 0) || (g < `OPFS_BIG_PAIR_FIRST);
			assign wr_this = access && pwrite_i && hit && (pair_sel == g);

			// reset to zero, written by software
			always @(posedge core_clk_i or posedge reset_i) begin
				if (reset_i) begin
					even_sel_q[g] <= `OPFS_SEL_RESET;
					odd_sel_q[g] <= `OPFS_SEL_RESET;
				end else if (wr_this && keep) begin
					// even low field, odd high field
					if (pstrb_i[0]) begin
						even_sel_q[g] <= pwdata_i[`OPFS_EVEN_LSB+`OPFS_SEL_W-1:`OPFS_EVEN_LSB];
					end
					if (pstrb_i[1]) begin
						odd_sel_q[g] <= pwdata_i[`OPFS_ODD_LSB+`OPFS_SEL_W-1:`OPFS_ODD_LSB];
					end
				end
			end

			// absent selectors read and act as zero
			assign sel_flat[(2*g+1)*`OPFS_SEL_W-1:2*g*`OPFS_SEL_W] =
				keep ? even_sel_q[g] : `OPFS_SEL_RESET;
			assign sel_flat[(2*g+2)*`OPFS_SEL_W-1:(2*g+1)*`OPFS_SEL_W] =
				keep ? odd_sel_q[g] : `OPFS_SEL_RESET;
		end
	endgenerate

	// ==========================================
	// read data
	// ==========================================
	reg [31:0] rd_word;
	always @* begin
		rd_word = 32'h00000000;
		if (hit) begin
			rd_word[`OPFS_EVEN_LSB+`OPFS_SEL_W-1:`OPFS_EVEN_LSB] =
				sel_flat[pair_sel*10 +: `OPFS_SEL_W];
			rd_word[`OPFS_ODD_LSB+`OPFS_SEL_W-1:`OPFS_ODD_LSB] =
				sel_flat[pair_sel*10+`OPFS_SEL_W +: `OPFS_SEL_W];
		end
	end

	// read data registered on setup so it is valid in access phase
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			prdata_o <= 32'h00000000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_o <= rd_word;
		end
	end

	// ==========================================
	// pin routing
	// ==========================================
	generate
		for (g = 0; g < `OPFS_PIN_CNT; g = g + 1) begin : g_pin
			opfs_pin_route #(
				.FUNC_CNT(FUNC_CNT)
			) u_route (
				.func_sel_i(sel_flat[g*`OPFS_SEL_W +: `OPFS_SEL_W]),
				.func_out_i(func_out_i),
				.func_oe_i(func_oe_i),
				.port_out_i(port_out_i[g]),
				.port_oe_i(port_oe_i[g]),
				.pin_out_o(pin_out_o[g]),
				.pin_oe_o(pin_oe_o[g]),
				.pin_periph_o(pin_periph_o[g])
			);
		end
	endgenerate

endmodule // opfs_top
`default_nettype wire

// >>> tb/opfs_monitor.sv
// Purpose: port checks for opfs_top
// Assumes: LARGE_PKG set, zero-wait apb
// Notes: bound after the module
`timescale 1ns/100ps
`default_nettype none
module opfs_monitor (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	input wire logic [13:0] port_out_i,
	input wire logic [13:0] pin_out_o,
	input wire logic [13:0] pin_periph_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	wire logic a = psel_i & penable_i;
	wire logic w0 = a && pwrite_i && paddr_i == 0 && pstrb_i == 4'hf;
	pad_zero_a: assert property (a && !pwrite_i |-> !(prdata_o & 32'hffffe0e0))
		else $error("pad bits set");
	bad_err_a: assert property (a && paddr_i > 12'h018 |-> pslverr_o)
		else $error("no error");
	good_ok_a: assert property (a && paddr_i < 12'h01c && !paddr_i[1:0] |-> !pslverr_o)
		else $error("false error");
	bad_keep_a: assert property (a && pwrite_i && paddr_i > 12'h018 |=> $stable(pin_periph_o))
		else $error("refused write acted");
	rst_clr_a: assert property ($fell(reset_i) |-> !pin_periph_o)
		else $error("not cleared");
	lane_keep_a: assert property (a && pwrite_i && paddr_i == 4 && pstrb_i == 2 |=>
		$stable(pin_periph_o[2])) else $error("even field hit");
	even_sel_a: assert property (w0 && pwdata_i[4:0] == 1 |=> pin_periph_o[0])
		else $error("even select");
	odd_sel_a: assert property (w0 && pwdata_i[12:8] == 2 |=> pin_periph_o[1])
		else $error("odd select");
	port_ctl_a: assert property (!((pin_out_o ^ port_out_i) & ~pin_periph_o))
		else $error("port lost");
	cover property (w0);
	cover property (a && pslverr_o);
	cover property ($fell(reset_i));
endmodule // opfs_monitor
bind opfs_top opfs_monitor opfs_monitor_inst(.*);
`default_nettype wire

// >>> tb/opfs_periph.sv
// Purpose: peripheral output model
// Assumes: one clock
// Notes: pattern moves every cycle
`timescale 1ns/100ps
`default_nettype none
module opfs_periph (
	input wire logic core_clk_i,
	output var logic [30:0] func_out_o,
	output wire logic [30:0] func_oe_o
);
	initial func_out_o = 31'h1;
	always @(posedge core_clk_i) func_out_o <= {func_out_o[29:0], ~func_out_o[30]};
	assign func_oe_o = ~func_out_o;
endmodule // opfs_periph
`default_nettype wire

// >>> tb/opfs_test.sv
// Purpose: register and pin tests for opfs_top
// Assumes: default parameters
// Notes: every wait is bounded
`timescale 1ns/100ps
`default_nettype none
module opfs_test;
	logic core_clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic pready_o, pslverr_o, e;
	logic [11:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, r;
	logic [3:0] pstrb_i = 0;
	logic [30:0] func_out_i, func_oe_i;
	logic [13:0] port_out_i = 14'h2a5a, port_oe_i = 14'h3fff, pin_out_o, pin_oe_o, pin_periph_o;
	int error_cnt = 0, n_tests = 0, k;
	always #5 core_clk_i = ~core_clk_i;
	opfs_top opfs_top_inst(.*);
	opfs_periph opfs_periph_inst(.core_clk_i, .func_out_o(func_out_i), .func_oe_o(func_oe_i));
	task print_verdict;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		i = 0;
		@(posedge core_clk_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= s;
		@(posedge core_clk_i);
		penable_i <= 1;
		@(posedge core_clk_i);
		while (pready_o !== 1'b1) begin
			i++;
			if (i > 9) begin
				error_cnt++;
				print_verdict();
			end
			@(posedge core_clk_i);
		end
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
	endtask
	initial begin
		repeat (12) @(posedge core_clk_i);
		reset_i <= 0;
		for (k = 0; k < 7; k++) begin
			apb(0, 12'(4 * k), 0, 0);
			cmp(r, 0);
			apb(1, 12'(4 * k), 32'hffffffff, 4'hf);
			apb(0, 12'(4 * k), 0, 0);
			cmp(r, 32'h1f1f);
		end
		apb(1, 12'h004, 0, 4'h2);
		apb(0, 12'h004, 0, 0);
		cmp(r, 32'h001f);
		apb(1, 12'h000, 32'h0201, 4'hf);
		#1 cmp({pin_periph_o[1:0], pin_oe_o[1:0], pin_out_o[1:0]}, {2'b11, func_oe_i[1:0], func_out_i[1:0]});
		apb(1, 12'h000, 0, 4'hf);
		#1 cmp({pin_periph_o[1:0], pin_oe_o[1:0], pin_out_o[1:0]}, {2'b00, port_oe_i[1:0], port_out_i[1:0]});
		apb(1, 12'h01c, 32'h0101, 4'hf);
		cmp(e, 1);
		apb(0, 12'h01c, 0, 0);
		cmp(r, 0);
		reset_i <= 1;
		@(posedge core_clk_i);
		reset_i <= 0;
		apb(0, 12'h018, 0, 0);
		cmp(r, 0);
		print_verdict();
	end
endmodule // opfs_test
`default_nettype wire
